// File: common/lioc_map.svh
// register map, field positions, reset values and timing counts for the input/open-loop control block
`ifndef LIOC_MAP_SVH
`define LIOC_MAP_SVH

`define LIOC_ADDR_W          4
`define LIOC_DATA_W          8
`define LIOC_CTRL_ADDR       4'h0
`define LIOC_PERIOD_ADDR     4'h1
`define LIOC_STATUS_ADDR     4'h2
`define LIOC_DUTY_ADDR       4'h3
`define LIOC_FREQ_ADDR       4'h4
`define LIOC_MODE_LSB        0
`define LIOC_MODE_W          3
`define LIOC_OPEN_LOOP_BIT   3
`define LIOC_ANALOG_BIT      4
`define LIOC_RATE_BIT        5
`define LIOC_CTRL_RST        8'h00
`define LIOC_PERIOD_RST      7'h00
`define LIOC_MODE_RTP        3'h5
`define LIOC_MODE_LIB        3'h0
`define LIOC_MODE_EXT        3'h3
`define LIOC_MODE_A2V        3'h4
`define LIOC_PWM_DIV         128
`define LIOC_PWM_DIV_LOG2    7
`define LIOC_CNT_W           16

`endif

// File: common/lioc_pkg.sv
// types shared by the input/open-loop control block
package lioc_pkg;

  typedef enum logic [1:0] {
    LIOC_SRC_NONE   = 2'b00,
    LIOC_SRC_PWM    = 2'b01,
    LIOC_SRC_ANALOG = 2'b10
  } lioc_src_t;

  typedef enum logic [1:0] {
    LIOC_FREQ_AUTO  = 2'b00,
    LIOC_FREQ_PWM   = 2'b01,
    LIOC_FREQ_FIXED = 2'b10
  } lioc_freq_t;

  typedef struct packed {
    logic [2:0] mode;
    logic       open_loop_select;
    logic       analog_select;
    logic       amplitude_update_rate;
  } lioc_ctrl_t;

  typedef struct packed {
    lioc_src_t  src;
    lioc_freq_t freq_src;
    logic       amp_update;
    logic       illegal_combo;
  } lioc_drive_t;

endpackage

// File: core/lioc_pwm_meas.sv
// measures duty and period of the synchronised pwm input
`timescale 1ns/10ps
`include "lioc_map.svh"
module lioc_pwm_meas
  import lioc_pkg::*;
#(
  parameter int CNT_W = `LIOC_CNT_W
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             pwm_in,
  output logic      [CNT_W-1:0] high_cnt,
  output logic      [CNT_W-1:0] period_cnt,
  output logic                  period_done
);

  typedef struct packed {
    logic             prev;
    logic [CNT_W-1:0] hi_acc;
    logic [CNT_W-1:0] per_acc;
    logic [CNT_W-1:0] hi_r;
    logic [CNT_W-1:0] per_r;
    logic             done;
  } lioc_meas_st_t;

  lioc_meas_st_t st_r;
  lioc_meas_st_t st_nxt;

  // ************************************************************
  // rising edge closes one pwm period
  // ************************************************************
  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = pwm_in;
    st_nxt.done = 1'b0;
    if (pwm_in && !st_r.prev) begin
      st_nxt.hi_r    = st_r.hi_acc;
      st_nxt.per_r   = st_r.per_acc;
      st_nxt.done    = 1'b1;
      st_nxt.hi_acc  = CNT_W'(1);
      st_nxt.per_acc = CNT_W'(1);
    end else begin
      if (st_r.per_acc != '1) begin
        st_nxt.per_acc = st_r.per_acc + CNT_W'(1);
      end
      if (pwm_in && st_r.hi_acc != '1) begin
        st_nxt.hi_acc = st_r.hi_acc + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign high_cnt    = st_r.hi_r;
  assign period_cnt  = st_r.per_r;
  assign period_done = st_r.done;

endmodule

// File: core/lioc_ctrl.sv
// input source and open-loop drive control with register port
`timescale 1ns/10ps
`include "lioc_map.svh"
// Contract
// RL1: In mode 3 the input pin is read as pwm when the source bit is 0 and as analog when it is 1.
// RL2: In pwm input mode the waveform amplitude follows the duty cycle on the input pin.
// RL3: In analog input mode the waveform amplitude follows the analog level on the input pin.
// RL4: With open-loop set the actuator is driven at the selected frequency, otherwise auto-resonance is used.
// RL5: Open-loop drive with pwm input takes its commutation frequency as the pwm frequency divided by 128.
// RL6: The host must run the pwm at 128 times the actuator resonant frequency in open-loop pwm drive.
// RL7: In real-time, library and audio-to-vibration modes open-loop frequency comes from the 7-bit period field.
// RL8: The host must not combine open-loop drive with analog input.
// RL9: The update rate bit selects one amplitude update per cycle when 0 and two when 1.
module lioc_ctrl
  import lioc_pkg::*;
#(
  parameter int ADDR_W = `LIOC_ADDR_W,
  parameter int DATA_W = `LIOC_DATA_W,
  parameter int CNT_W  = `LIOC_CNT_W,
  parameter int ADC_W  = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              input_trigger_pin,
  input  wire logic [ADC_W-1:0]  analog_level,
  output logic      [7:0]        drive_amplitude,
  output logic                   amplitude_strobe,
  output logic      [CNT_W-1:0]  commutation_period,
  output logic                   open_loop_active,
  output logic      [1:0]        amplitude_update_count
);

  typedef struct packed {
    logic [1:0]       pin_sync;
    lioc_ctrl_t       ctrl;
    logic [6:0]       fixed_drive_period;
    lioc_drive_t      drive;
    logic [7:0]       amp;
    logic             amp_stb;
    logic [CNT_W-1:0] comm_per;
    logic [DATA_W-1:0] rdata;
    logic             odd_half;
    logic [CNT_W-1:0] half_cnt;
    logic             ol_act;
    logic [1:0]       upd_cnt;
  } lioc_state_t;

  lioc_state_t st_r;
  lioc_state_t st_nxt;

  logic [CNT_W-1:0] high_cnt;
  logic [CNT_W-1:0] period_cnt;
  logic             period_done;

  // ************************************************************
  // pwm period and duty measurement
  // ************************************************************
  lioc_pwm_meas #(
    .CNT_W (CNT_W)
  ) u_meas (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .pwm_in      (st_r.pin_sync[1]),
    .high_cnt    (high_cnt),
    .period_cnt  (period_cnt),
    .period_done (period_done)
  );

  function automatic logic [7:0] duty_scale(input logic [CNT_W-1:0] hi, input logic [CNT_W-1:0] per);
    logic [CNT_W+7:0] num;
    logic [CNT_W+7:0] q;
    num = {hi, 8'h00} - {8'h00, hi};
    q   = (per == '0) ? '0 : num / {8'h00, per};
    duty_scale = (q > (CNT_W+8)'(8'hFF)) ? 8'hFF : q[7:0];
  endfunction

  function automatic logic [7:0] analog_scale(input logic [ADC_W-1:0] lvl);
    logic [15:0] wide;
    wide = 16'(lvl) << 8;
    analog_scale = wide[ADC_W+7 -: 8];
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic in_ext;
    logic fixed_mode;
    logic update_pt;
    logic half_pt;
    in_ext = 1'b0;
    fixed_mode = 1'b0;
    update_pt = 1'b0;
    half_pt = 1'b0;
    st_nxt          = st_r;
    st_nxt.pin_sync = {st_r.pin_sync[0], input_trigger_pin};
    st_nxt.amp_stb  = 1'b0;
    st_nxt.rdata    = '0;

    // ************************************************************
    // register write
    // ************************************************************
    if (reg_wr) begin
      case (reg_addr)
        `LIOC_CTRL_ADDR: begin
          st_nxt.ctrl.mode                  = reg_wdata[`LIOC_MODE_LSB +: `LIOC_MODE_W];
          st_nxt.ctrl.open_loop_select      = reg_wdata[`LIOC_OPEN_LOOP_BIT];
          st_nxt.ctrl.analog_select         = reg_wdata[`LIOC_ANALOG_BIT];
          st_nxt.ctrl.amplitude_update_rate = reg_wdata[`LIOC_RATE_BIT];
        end
        `LIOC_PERIOD_ADDR: st_nxt.fixed_drive_period = reg_wdata[6:0];
        default: ;
      endcase
    end

    // ************************************************************
    // register read
    // ************************************************************
    if (reg_rd) begin
      case (reg_addr)
        `LIOC_CTRL_ADDR:   st_nxt.rdata = DATA_W'({st_r.ctrl.amplitude_update_rate, st_r.ctrl.analog_select,
                                                   st_r.ctrl.open_loop_select, st_r.ctrl.mode});
        `LIOC_PERIOD_ADDR: st_nxt.rdata = DATA_W'(st_r.fixed_drive_period);
        `LIOC_STATUS_ADDR: st_nxt.rdata = DATA_W'({st_r.drive.illegal_combo, st_r.drive.amp_update,
                                                   st_r.drive.freq_src, st_r.drive.src});
        `LIOC_DUTY_ADDR:   st_nxt.rdata = DATA_W'(st_r.amp);
        `LIOC_FREQ_ADDR:   st_nxt.rdata = DATA_W'(st_r.comm_per >> `LIOC_PWM_DIV_LOG2);
        default:           st_nxt.rdata = '0;
      endcase
    end

    // ************************************************************
    // drive source
    // ************************************************************
    in_ext = (st_r.ctrl.mode == `LIOC_MODE_EXT);
    fixed_mode = (st_r.ctrl.mode == `LIOC_MODE_RTP) || (st_r.ctrl.mode == `LIOC_MODE_LIB) ||
                 (st_r.ctrl.mode == `LIOC_MODE_A2V);

    // source selection from mode and source bit [RL1]
    if (in_ext) begin
      st_nxt.drive.src = st_r.ctrl.analog_select ? LIOC_SRC_ANALOG : LIOC_SRC_PWM; // [RL1]
    end else begin
      st_nxt.drive.src = LIOC_SRC_NONE;
    end

    // open-loop frequency source, else auto-resonance [RL4]
    if (!st_r.ctrl.open_loop_select) begin
      st_nxt.drive.freq_src = LIOC_FREQ_AUTO; // [RL4]
    end else if (in_ext && !st_r.ctrl.analog_select) begin
      st_nxt.drive.freq_src = LIOC_FREQ_PWM; // [RL5]
    end else if (fixed_mode) begin
      st_nxt.drive.freq_src = LIOC_FREQ_FIXED; // [RL7]
    end else begin
      st_nxt.drive.freq_src = LIOC_FREQ_AUTO;
    end
    // unsupported pairing is flagged and drive falls back to auto-resonance [RL8]
    st_nxt.drive.illegal_combo = st_r.ctrl.open_loop_select && in_ext && st_r.ctrl.analog_select; // [RL8]
    st_nxt.drive.amp_update    = st_r.ctrl.amplitude_update_rate;
    st_nxt.ol_act              = (st_nxt.drive.freq_src != LIOC_FREQ_AUTO); // [RL4]
    st_nxt.upd_cnt             = st_nxt.drive.amp_update ? 2'h2 : 2'h1; // [RL9]

    case (st_r.drive.freq_src)
      LIOC_FREQ_PWM: begin
        if (period_done) begin
          st_nxt.comm_per = period_cnt << `LIOC_PWM_DIV_LOG2; // [RL5] [RL6]
        end
      end
      LIOC_FREQ_FIXED: st_nxt.comm_per = CNT_W'(st_r.fixed_drive_period) << `LIOC_PWM_DIV_LOG2; // [RL7]
      default: st_nxt.comm_per = '0;
    endcase

    // ************************************************************
    // amplitude update
    // ************************************************************
    // once per pwm period, plus once halfway when the rate bit is set [RL9]
    if (period_done) begin
      st_nxt.half_cnt = CNT_W'(1);
    end else if (st_r.half_cnt != '1) begin
      st_nxt.half_cnt = st_r.half_cnt + CNT_W'(1);
    end
    half_pt   = st_r.ctrl.amplitude_update_rate && !st_r.odd_half && (st_r.half_cnt > CNT_W'(1)) &&
                (st_r.half_cnt == (period_cnt >> 1)); // [RL9]
    update_pt = period_done || half_pt;
    if (period_done) begin
      st_nxt.odd_half = 1'b0;
    end else if (half_pt) begin
      st_nxt.odd_half = 1'b1;
    end
    case (st_r.drive.src)
      LIOC_SRC_PWM: begin
        if (update_pt) begin
          st_nxt.amp     = duty_scale(high_cnt, period_cnt); // [RL2] [RL9]
          st_nxt.amp_stb = 1'b1;
        end
      end
      LIOC_SRC_ANALOG: begin
        st_nxt.amp     = analog_scale(analog_level); // [RL3]
        st_nxt.amp_stb = (st_r.amp != analog_scale(analog_level));
      end
      default: st_nxt.amp = st_r.amp;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r         <= '0;
      st_r.upd_cnt <= 2'h1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata              = st_r.rdata;
  assign drive_amplitude        = st_r.amp;
  assign amplitude_strobe       = st_r.amp_stb;
  assign commutation_period     = st_r.comm_per;
  assign open_loop_active       = st_r.ol_act;
  assign amplitude_update_count = st_r.upd_cnt; // [RL9]

endmodule

// File: testbench/lioc_host_pwm.sv
// host model that drives the input pin with a steady pwm pattern
`timescale 1ns/10ps
module lioc_host_pwm (
  input  wire logic       ref_clk,
  input  wire logic       pwm_en,
  input  wire logic [7:0] period_cyc,
  input  wire logic [7:0] high_cyc,
  output logic            pin = 1'b0
);
  logic [7:0] cnt = 8'h00;

  // pin is driven low while the host is not playing pwm
  // period_cyc is the actuator cycle divided by 128
  always @(posedge ref_clk) begin
    cnt <= (!pwm_en || cnt >= period_cyc - 8'h01) ? 8'h00 : cnt + 8'h01;
    pin <= pwm_en && (cnt < high_cyc);
  end
endmodule

// File: testbench/lioc_ctrl_props.sv
// port assertions of the input/open-loop control block
`timescale 1ns/10ps
`include "lioc_map.svh"
module lioc_ctrl_props (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        input_trigger_pin,
  input wire logic [7:0]  analog_level,
  input wire logic [7:0]  drive_amplitude,
  input wire logic        amplitude_strobe,
  input wire logic [15:0] commutation_period,
  input wire logic        open_loop_active,
  input wire logic [1:0]  amplitude_update_count
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****************
  // checks
  // ****************
  sequence s_ctrl_wr;
    reg_wr && reg_addr == `LIOC_CTRL_ADDR;
  endsequence
  sequence s_ctrl_rd;
    reg_rd && reg_addr == `LIOC_CTRL_ADDR;
  endsequence
  property p_readback;
    logic [7:0] w;
    (s_ctrl_wr, w = reg_wdata) ##2 s_ctrl_rd |=> reg_rdata == (w & 8'h3F);
  endproperty
  property p_rate;
    logic [7:0] w;
    (s_ctrl_wr, w = reg_wdata) |-> ##2 amplitude_update_count == (w[5] ? 2'h2 : 2'h1);
  endproperty
  a_ctrl_readback: assert property (p_readback)
    else $error("control readback wrong");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read answer");
  a_rate_count: assert property (p_rate)
    else $error("update count wrong");
  a_ol_pwm: assert property (s_ctrl_wr ##0 (reg_wdata & 8'h1F) == 8'h0B |-> ##2 open_loop_active)
    else $error("pwm open loop not active");
  a_ol_fixed: assert property (s_ctrl_wr ##0 reg_wdata[3] && reg_wdata[2:0] inside {3'h0, 3'h4, 3'h5}
    |-> ##2 open_loop_active)
    else $error("fixed open loop not active");
  a_ol_analog: assert property (s_ctrl_wr ##0 (reg_wdata & 8'h1F) == 8'h1B |-> ##2 !open_loop_active)
    else $error("open loop with analog input");
  a_auto_drive: assert property (s_ctrl_wr ##0 !reg_wdata[3]
    |-> ##2 !open_loop_active ##[0:4] commutation_period == 16'h0000)
    else $error("auto resonance not taken");
  a_period_mult: assert property (commutation_period[6:0] == 7'h00)
    else $error("period not a multiple of 128");
  a_strobe_pulse: assert property (amplitude_strobe |=> !amplitude_strobe)
    else $error("amplitude strobe too long");
endmodule

// File: testbench/lra_input_openloop_control_tb.sv
// self-checking bench for the input/open-loop control block
`timescale 1ns/10ps
`include "lioc_map.svh"
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module lra_input_openloop_control_tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        pin;
  logic        pwm_en = 1'b0;
  logic [7:0]  analog_level = 8'h00;
  logic [7:0]  drive_amplitude;
  logic        amplitude_strobe;
  logic [15:0] commutation_period;
  logic        open_loop_active;
  logic [1:0]  amplitude_update_count;
  logic [7:0]  rdv;
  int          bad_count = 0;
  int          tests_run = 0;
  int          stb_cnt = 0;
  int          n0;
  logic [6:0]  per [3] = '{7'h7F, 7'h01, 7'h40};
  logic [2:0]  mde [3] = '{`LIOC_MODE_LIB, `LIOC_MODE_A2V, `LIOC_MODE_RTP};
  logic [7:0]  lvl [2] = '{8'h5A, 8'hC3};

  lioc_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .input_trigger_pin(pin),
    .analog_level(analog_level), .drive_amplitude(drive_amplitude), .amplitude_strobe(amplitude_strobe),
    .commutation_period(commutation_period), .open_loop_active(open_loop_active),
    .amplitude_update_count(amplitude_update_count));
  // 20-cycle pwm at half duty
  lioc_host_pwm i_host (.ref_clk(ref_clk), .pwm_en(pwm_en), .period_cyc(8'h14), .high_cyc(8'h0A),
    .pin(pin));
  // counts amplitude strobes for the update rate checks
  always @(posedge ref_clk) begin
    if (amplitude_strobe) stb_cnt <= stb_cnt + 1;
  end

  // ****************
  // bus, wait and finish tasks
  // ****************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
    `CHK($sformatf("register %h", a), e, rdv)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic complete_run();
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial forever #4 ref_clk = ~ref_clk;
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end

  // ****************
  // tests
  // ****************
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    #1 `CHK("update count", 2'h1, amplitude_update_count)
    rchk(`LIOC_CTRL_ADDR, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(`LIOC_PERIOD_ADDR, {1'b0, per[i]});
      wr(`LIOC_CTRL_ADDR, {5'h01, mde[i]});
      rchk(`LIOC_CTRL_ADDR, {5'h01, mde[i]});
      cyc(4);
      `CHK("fixed period", {2'h0, per[i], 7'h00}, commutation_period)
      `CHK("open loop", 1'b1, open_loop_active)
      rchk(`LIOC_STATUS_ADDR, 8'h08);
    end
    @(posedge ref_clk);
    pwm_en <= 1'b1;
    wr(`LIOC_CTRL_ADDR, 8'h0B);
    cyc(100);
    `CHK("pwm period", 16'h0A00, commutation_period)
    `CHK("pwm open loop", 1'b1, open_loop_active)
    `CHK("duty amplitude", 1'b1, drive_amplitude inside {8'h7F, 8'h80})
    rchk(`LIOC_FREQ_ADDR, 8'h14);
    rchk(`LIOC_STATUS_ADDR, 8'h05);
    rchk(`LIOC_DUTY_ADDR, 8'h7F);
    n0 = stb_cnt;
    cyc(40);
    `CHK("strobes once", 2, stb_cnt - n0)
    wr(`LIOC_CTRL_ADDR, 8'h2B);
    cyc(4);
    `CHK("update count", 2'h2, amplitude_update_count)
    rchk(`LIOC_STATUS_ADDR, 8'h15);
    n0 = stb_cnt;
    cyc(40);
    `CHK("strobes twice", 4, stb_cnt - n0)
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      analog_level <= lvl[i];
      wr(`LIOC_CTRL_ADDR, 8'h13);
      cyc(8);
      `CHK("analog amplitude", lvl[i], drive_amplitude)
    end
    `CHK("auto resonance", 1'b0, open_loop_active)
    `CHK("auto period", 16'h0000, commutation_period)
    rchk(`LIOC_STATUS_ADDR, 8'h02);
    wr(`LIOC_CTRL_ADDR, 8'h1B);
    cyc(4);
    `CHK("analog open loop", 1'b0, open_loop_active)
    rchk(`LIOC_STATUS_ADDR, 8'h22);
    rchk(4'hF, 8'h00);
    rchk(`LIOC_PERIOD_ADDR, 8'h40);
    complete_run();
  end
endmodule

bind lioc_ctrl lioc_ctrl_props i_props (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .input_trigger_pin(input_trigger_pin), .analog_level(analog_level), .drive_amplitude(drive_amplitude),
  .amplitude_strobe(amplitude_strobe), .commutation_period(commutation_period),
  .open_loop_active(open_loop_active), .amplitude_update_count(amplitude_update_count));
